// *** verilog/orgr_defines.svh ***
/*
  Offsets, field positions, reset values and timing counts for the output
  routing and gain register bank. Assumes inclusion by bare name.
*/
`ifndef ORGR_DEFINES_SVH
`define ORGR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets on page one
// ----------------------------------------------------------------------
`define ORGR_OFS_MIX_ROUTE   8'h23
`define ORGR_OFS_LVOL_HP     8'h24
`define ORGR_OFS_RVOL_HP     8'h25
`define ORGR_OFS_LVOL_SPK    8'h26
`define ORGR_OFS_RVOL_SPK    8'h27
`define ORGR_OFS_LHP_DRV     8'h28
`define ORGR_OFS_RHP_DRV     8'h29

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ORGR_RST_MIX_ROUTE   8'h00
`define ORGR_RST_VOL         8'h7f
`define ORGR_RST_HP_DRV      8'h02

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ORGR_MIX_LDAC_HI     7
`define ORGR_MIX_LDAC_LO     6
`define ORGR_MIX_ANALOG_INPUT_ONE_L      5
`define ORGR_MIX_ANALOG_INPUT_TWO_L      4
`define ORGR_MIX_RDAC_HI     3
`define ORGR_MIX_RDAC_LO     2
`define ORGR_MIX_ANALOG_INPUT_TWO_R      1
`define ORGR_MIX_DIFF        0
`define ORGR_VOL_ROUTE       7
`define ORGR_VOL_HI          6
`define ORGR_VOL_LO          0
`define ORGR_DRV_GAIN_HI     6
`define ORGR_DRV_GAIN_LO     3
`define ORGR_DRV_UNMUTE      2
`define ORGR_DRV_PDHIZ       1
`define ORGR_DRV_APPLIED     0

// ----------------------------------------------------------------------
// Gain settling time, default 1 us at 100 MHz (10 ns period)
// ----------------------------------------------------------------------
`define ORGR_SETTLE_NS       1000
`define ORGR_CLK_NS          10
`define ORGR_SETTLE_CYC      ((`ORGR_SETTLE_NS + `ORGR_CLK_NS - 1) / `ORGR_CLK_NS)

`endif

// *** verilog/orgr_pkg.sv ***
/*
  Types for the output routing and gain register bank.
  Assumes nothing of its surroundings.
*/
package orgr_pkg;

  // DAC routing destination decoded from a two-bit field
  typedef enum logic [1:0] {
    ORGR_DAC_NONE,
    ORGR_DAC_MIXER,
    ORGR_DAC_DIRECT,
    ORGR_DAC_RSVD
  } orgr_dac_route_type;

  // Settling tracker states
  typedef enum logic [0:0] {
    ORGR_SETTLED,
    ORGR_PENDING
  } orgr_settle_type;

endpackage

// *** verilog/orgr_dac_decode.sv ***
/*
  Decodes one DAC routing field into one-hot path enables.
  Assumes a registered field value from the same clock domain.
*/
`timescale 1ns/1ps
module orgr_dac_decode
  import orgr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic [1:0] routeField,
  output logic            toMixer,
  output logic            toDirect
);

  orgr_dac_route_type route;

  // Reserved code and unrouted both leave every path open
  always_comb begin
    case (routeField)
      2'h0:    route = ORGR_DAC_NONE;
      2'h1:    route = ORGR_DAC_MIXER;
      2'h2:    route = ORGR_DAC_DIRECT;
      default: route = ORGR_DAC_RSVD;
    endcase
  end

  // Registered so path enables never glitch at the switches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toMixer  <= 1'b0;
      toDirect <= 1'b0;
    end else if (clkEn) begin
      toMixer  <= (route == ORGR_DAC_MIXER);
      toDirect <= (route == ORGR_DAC_DIRECT);
    end
  end

endmodule

// *** verilog/orgr_settle.sv ***
/*
  Tracks whether a freshly written gain has reached its driver.
  Assumes a one-cycle change pulse from the same clock domain.
*/
`timescale 1ns/1ps
`include "orgr_defines.svh"
module orgr_settle
  import orgr_pkg::*;
#(
  parameter int SETTLE_CYC = `ORGR_SETTLE_CYC
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic gainChange,
  output logic      applied
);

  orgr_settle_type state_r;
  logic [15:0]     count_r;

  // A new change restarts the wait, so the flag only rises after the last
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ORGR_PENDING;
      count_r <= 16'h0000;
    end else if (clkEn) begin
      case (state_r)
        ORGR_SETTLED: begin
          if (gainChange) begin
            state_r <= ORGR_PENDING;
            count_r <= 16'h0000;
          end
        end
        ORGR_PENDING: begin
          if (gainChange) begin
            count_r <= 16'h0000;
          end else if (count_r >= 16'(SETTLE_CYC - 1)) begin
            state_r <= ORGR_SETTLED;
          end else begin
            count_r <= count_r + 16'h0001;
          end
        end
        default: state_r <= ORGR_PENDING;
      endcase
    end
  end

  // Status output registered from the state, forced low in any cycle with a change
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      applied <= 1'b0;
    end else if (clkEn) begin
      applied <= (state_r == ORGR_SETTLED) && !gainChange;
    end
  end

endmodule

// *** verilog/orgr_output_routing_gain_regs.sv ***
/*
  Register bank for the analog output path: mixer routing, analog volume
  routing and codes, headphone driver gain, mute and power-down style,
  plus read-only gain-applied flags.
  Assumes a simple synchronous register port from the device core, one
  access per cycle, page one already selected by the caller.
*/
`timescale 1ns/1ps
`include "orgr_defines.svh"
module orgr_output_routing_gain_regs
  import orgr_pkg::*;
#(
  parameter int SETTLE_CYC = `ORGR_SETTLE_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            leftDacToMixer,
  output logic            leftDacToHeadphone,
  output logic            rightDacToMixer,
  output logic            rightDacToHeadphone,
  output logic            analogInputOneToLeftMixer,
  output logic            analogInputTwoToLeftMixer,
  output logic            analogInputTwoToRightMixer,
  output logic            leftToRightHeadphoneDiff,
  output logic            leftVolToHeadphone,
  output logic            rightVolToHeadphone,
  output logic            leftVolToSpeaker,
  output logic            rightVolToSpeaker,
  output logic      [6:0] leftHeadphoneVol,
  output logic      [6:0] rightHeadphoneVol,
  output logic      [6:0] leftSpeakerVol,
  output logic      [6:0] rightSpeakerVol,
  output logic      [3:0] leftHeadphoneGain,
  output logic      [3:0] rightHeadphoneGain,
  output logic            leftHeadphoneUnmute,
  output logic            rightHeadphoneUnmute,
  output logic            leftHeadphonePdHiZ,
  output logic            rightHeadphonePdHiZ
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] mixRoute_r;
  logic [7:0] vol_r [4];       // Left hp, right hp, left spk, right spk
  logic [7:0] hpDrv_r [2];     // Left, right; bit 0 not stored
  logic [1:0] hpApplied;
  logic [1:0] hpGainChange;
  logic       lDacMix;
  logic       lDacDir;
  logic       rDacMix;
  logic       rDacDir;

  // ----------------------------------------------------------------------
  // Mixer routing register
  // ----------------------------------------------------------------------
  // Stores every bit; reserved route codes are stored but decode to nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mixRoute_r <= `ORGR_RST_MIX_ROUTE;
    end else if (clkEn && regWrEn && regAddr == `ORGR_OFS_MIX_ROUTE) begin
      mixRoute_r <= regWrData;
    end
  end

  // ----------------------------------------------------------------------
  // Volume registers, one per destination
  // ----------------------------------------------------------------------
  // A change of volume code on a headphone path also marks its driver
  // pending, since the headphone level depends on it
  genvar gv;
  generate
    for (gv = 0; gv < 4; gv++) begin : g_vol
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          vol_r[gv] <= `ORGR_RST_VOL;
        end else if (clkEn && regWrEn && regAddr == (`ORGR_OFS_LVOL_HP + 8'(gv))) begin
          vol_r[gv] <= regWrData;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Headphone driver registers and their settling trackers
  // ----------------------------------------------------------------------
  generate
    for (gv = 0; gv < 2; gv++) begin : g_hp
      logic drvHit;
      logic volHit;
      assign drvHit = clkEn && regWrEn && regAddr == (`ORGR_OFS_LHP_DRV + 8'(gv));
      assign volHit = clkEn && regWrEn && regAddr == (`ORGR_OFS_LVOL_HP + 8'(gv));

      // Bit 0 is status only; writes to it are dropped
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          hpDrv_r[gv] <= `ORGR_RST_HP_DRV;
        end else if (drvHit) begin
          hpDrv_r[gv] <= {regWrData[7:1], 1'b0};
        end
      end

      // Only a real change of gain or volume restarts the wait
      assign hpGainChange[gv] =
        (drvHit && regWrData[`ORGR_DRV_GAIN_HI:`ORGR_DRV_GAIN_LO] !=
                   hpDrv_r[gv][`ORGR_DRV_GAIN_HI:`ORGR_DRV_GAIN_LO]) ||
        (volHit && regWrData[`ORGR_VOL_HI:`ORGR_VOL_LO] !=
                   vol_r[gv][`ORGR_VOL_HI:`ORGR_VOL_LO]);

      orgr_settle #(
        .SETTLE_CYC (SETTLE_CYC)
      ) u_settle (
        .clk        (clk),
        .rst_n      (rst_n),
        .clkEn      (clkEn),
        .gainChange (hpGainChange[gv]),
        .applied    (hpApplied[gv])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // DAC route decoders
  // ----------------------------------------------------------------------
  orgr_dac_decode u_left_dac (
    .clk        (clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .routeField (mixRoute_r[`ORGR_MIX_LDAC_HI:`ORGR_MIX_LDAC_LO]),
    .toMixer    (lDacMix),
    .toDirect   (lDacDir)
  );

  orgr_dac_decode u_right_dac (
    .clk        (clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .routeField (mixRoute_r[`ORGR_MIX_RDAC_HI:`ORGR_MIX_RDAC_LO]),
    .toMixer    (rDacMix),
    .toDirect   (rDacDir)
  );

  // ----------------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------------
  // Re-registered so every output comes straight from a flip-flop; costs one
  // extra cycle of latency, harmless for analog switch control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      leftDacToMixer             <= 1'b0;
      leftDacToHeadphone         <= 1'b0;
      rightDacToMixer            <= 1'b0;
      rightDacToHeadphone        <= 1'b0;
      analogInputOneToLeftMixer  <= 1'b0;
      analogInputTwoToLeftMixer  <= 1'b0;
      analogInputTwoToRightMixer <= 1'b0;
      leftToRightHeadphoneDiff   <= 1'b0;
    end else if (clkEn) begin
      leftDacToMixer             <= lDacMix;
      leftDacToHeadphone         <= lDacDir;
      rightDacToMixer            <= rDacMix;
      rightDacToHeadphone        <= rDacDir;
      analogInputOneToLeftMixer  <= mixRoute_r[`ORGR_MIX_ANALOG_INPUT_ONE_L];
      analogInputTwoToLeftMixer  <= mixRoute_r[`ORGR_MIX_ANALOG_INPUT_TWO_L];
      analogInputTwoToRightMixer <= mixRoute_r[`ORGR_MIX_ANALOG_INPUT_TWO_R];
      leftToRightHeadphoneDiff   <= mixRoute_r[`ORGR_MIX_DIFF];
    end
  end

  // Volume path enables and codes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      leftVolToHeadphone  <= 1'b0;
      rightVolToHeadphone <= 1'b0;
      leftVolToSpeaker    <= 1'b0;
      rightVolToSpeaker   <= 1'b0;
      leftHeadphoneVol    <= 7'h7f;
      rightHeadphoneVol   <= 7'h7f;
      leftSpeakerVol      <= 7'h7f;
      rightSpeakerVol     <= 7'h7f;
    end else if (clkEn) begin
      leftVolToHeadphone  <= vol_r[0][`ORGR_VOL_ROUTE];
      rightVolToHeadphone <= vol_r[1][`ORGR_VOL_ROUTE];
      leftVolToSpeaker    <= vol_r[2][`ORGR_VOL_ROUTE];
      rightVolToSpeaker   <= vol_r[3][`ORGR_VOL_ROUTE];
      leftHeadphoneVol    <= vol_r[0][`ORGR_VOL_HI:`ORGR_VOL_LO];
      rightHeadphoneVol   <= vol_r[1][`ORGR_VOL_HI:`ORGR_VOL_LO];
      leftSpeakerVol      <= vol_r[2][`ORGR_VOL_HI:`ORGR_VOL_LO];
      rightSpeakerVol     <= vol_r[3][`ORGR_VOL_HI:`ORGR_VOL_LO];
    end
  end

  // Headphone driver controls; reserved gain codes pass through unchanged,
  // software is expected never to write them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      leftHeadphoneGain    <= 4'h0;
      rightHeadphoneGain   <= 4'h0;
      leftHeadphoneUnmute  <= 1'b0;
      rightHeadphoneUnmute <= 1'b0;
      leftHeadphonePdHiZ   <= 1'b1;
      rightHeadphonePdHiZ  <= 1'b1;
    end else if (clkEn) begin
      leftHeadphoneGain    <= hpDrv_r[0][`ORGR_DRV_GAIN_HI:`ORGR_DRV_GAIN_LO];
      rightHeadphoneGain   <= hpDrv_r[1][`ORGR_DRV_GAIN_HI:`ORGR_DRV_GAIN_LO];
      leftHeadphoneUnmute  <= hpDrv_r[0][`ORGR_DRV_UNMUTE];
      rightHeadphoneUnmute <= hpDrv_r[1][`ORGR_DRV_UNMUTE];
      leftHeadphonePdHiZ   <= hpDrv_r[0][`ORGR_DRV_PDHIZ];
      rightHeadphonePdHiZ  <= hpDrv_r[1][`ORGR_DRV_PDHIZ];
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Registered read data; unmapped offsets return zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (clkEn && regRdEn) begin
      case (regAddr)
        `ORGR_OFS_MIX_ROUTE: regRdData <= mixRoute_r;
        `ORGR_OFS_LVOL_HP:   regRdData <= vol_r[0];
        `ORGR_OFS_RVOL_HP:   regRdData <= vol_r[1];
        `ORGR_OFS_LVOL_SPK:  regRdData <= vol_r[2];
        `ORGR_OFS_RVOL_SPK:  regRdData <= vol_r[3];
        `ORGR_OFS_LHP_DRV:   regRdData <= {hpDrv_r[0][7:1], hpApplied[0]};
        `ORGR_OFS_RHP_DRV:   regRdData <= {hpDrv_r[1][7:1], hpApplied[1]};
        default:             regRdData <= 8'h00;
      endcase
    end
  end

endmodule

// *** sim/orgr_regs_sva.sv ***
/*
  Checker for the output routing and gain register bank.
  Assumes clkEn stays high for four cycles after each checked write.
*/
`timescale 1ns/1ps
module orgr_regs_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clkEn,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       leftDacToMixer,
  input wire logic       leftDacToHeadphone,
  input wire logic       rightDacToMixer,
  input wire logic       rightDacToHeadphone,
  input wire logic       analogInputOneToLeftMixer,
  input wire logic       analogInputTwoToLeftMixer,
  input wire logic       analogInputTwoToRightMixer,
  input wire logic       leftToRightHeadphoneDiff,
  input wire logic       leftVolToHeadphone,
  input wire logic [6:0] leftHeadphoneVol,
  input wire logic       rightVolToSpeaker,
  input wire logic [6:0] rightSpeakerVol,
  input wire logic [3:0] leftHeadphoneGain,
  input wire logic       leftHeadphoneUnmute,
  input wire logic       leftHeadphonePdHiZ
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Delayed write data, so a consequent can see the value that caused it
  logic [7:0] wd1_r, wd2_r, wd3_r, wd4_r;
  always_ff @(posedge clk) begin
    wd1_r <= regWrData;
    wd2_r <= wd1_r;
    wd3_r <= wd2_r;
    wd4_r <= wd3_r;
  end
  // Decoded outputs trail the write by one more stage than plain bits
  property p_ldac;
    clkEn && regWrEn && regAddr == 8'h23 |-> ##4
      leftDacToMixer == (wd4_r[7:6] == 2'b01) && leftDacToHeadphone == (wd4_r[7:6] == 2'b10);
  endproperty
  a_ldac: assert property (p_ldac) else $error("left dac decode");
  property p_rdac;
    clkEn && regWrEn && regAddr == 8'h23 |-> ##4
      rightDacToMixer == (wd4_r[3:2] == 2'b01) && rightDacToHeadphone == (wd4_r[3:2] == 2'b10);
  endproperty
  a_rdac: assert property (p_rdac) else $error("right dac decode");
  property p_mixbits;
    clkEn && regWrEn && regAddr == 8'h23 |-> ##3 {analogInputOneToLeftMixer,
      analogInputTwoToLeftMixer, analogInputTwoToRightMixer, leftToRightHeadphoneDiff}
      == {wd3_r[5], wd3_r[4], wd3_r[1], wd3_r[0]};
  endproperty
  a_mixbits: assert property (p_mixbits) else $error("mixer bits");
  property p_hpvol;
    clkEn && regWrEn && regAddr == 8'h24 |-> ##3 {leftVolToHeadphone, leftHeadphoneVol} == wd3_r;
  endproperty
  a_hpvol: assert property (p_hpvol) else $error("headphone volume");
  property p_spkvol;
    clkEn && regWrEn && regAddr == 8'h27 |-> ##3 {rightVolToSpeaker, rightSpeakerVol} == wd3_r;
  endproperty
  a_spkvol: assert property (p_spkvol) else $error("speaker volume");
  property p_drv;
    clkEn && regWrEn && regAddr == 8'h28 |-> ##3
      {leftHeadphoneGain, leftHeadphoneUnmute, leftHeadphonePdHiZ} == wd3_r[6:1];
  endproperty
  a_drv: assert property (p_drv) else $error("driver fields");
  // Out of reset the driver is muted, gain zero, high impedance, volume all ones
  property p_rstval;
    $rose(rst_n) |-> leftHeadphoneVol == 7'h7f && leftHeadphonePdHiZ
      && !leftHeadphoneUnmute && leftHeadphoneGain == 4'h0 && !leftVolToHeadphone;
  endproperty
  a_rstval: assert property (p_rstval) else $error("reset values");
  property p_unmapped;
    clkEn && regRdEn && (regAddr < 8'h23 || regAddr > 8'h29) |=> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule

// *** sim/orgr_testbench.sv ***
/*
  Self-checking bench for the output routing and gain register bank.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import orgr_pkg::*;
  localparam int SETTLE = 4;
  logic       clk, rst_n, clkEn, regWrEn, regRdEn;
  logic [7:0] regAddr, regWrData, regRdData;
  logic       ldm, ldh, rdm, rdh, a1l, a2l, a2r, dif, lvh, rvh, lvs, rvs, lum, rum, lpz, rpz;
  logic [6:0] lhv, rhv, lsv, rsv;
  logic [3:0] lhg, rhg;
  int         num_errors, cmp_count, cycleCount;
  orgr_output_routing_gain_regs #(.SETTLE_CYC(SETTLE)) u_dut (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .leftDacToMixer(ldm), .leftDacToHeadphone(ldh), .rightDacToMixer(rdm),
    .rightDacToHeadphone(rdh), .analogInputOneToLeftMixer(a1l),
    .analogInputTwoToLeftMixer(a2l), .analogInputTwoToRightMixer(a2r),
    .leftToRightHeadphoneDiff(dif), .leftVolToHeadphone(lvh), .rightVolToHeadphone(rvh),
    .leftVolToSpeaker(lvs), .rightVolToSpeaker(rvs), .leftHeadphoneVol(lhv),
    .rightHeadphoneVol(rhv), .leftSpeakerVol(lsv), .rightSpeakerVol(rsv),
    .leftHeadphoneGain(lhg), .rightHeadphoneGain(rhg), .leftHeadphoneUnmute(lum),
    .rightHeadphoneUnmute(rum), .leftHeadphonePdHiZ(lpz), .rightHeadphonePdHiZ(rpz));
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  // Data is registered, so it is taken one edge after the read edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRdEn <= 1'b1; regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    #1 chk(regRdData, exp);
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the some 134 cycles the sequence needs
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    static logic [7:0] rstVal [7] = '{8'h00, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h03, 8'h03};
    rst_n = 1'b0; clkEn = 1'b1; regWrEn = 1'b0; regRdEn = 1'b0;
    regAddr = 8'h00; regWrData = 8'h00;
    num_errors = 0; cmp_count = 0; cycleCount = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (SETTLE + 6) @(posedge clk);
    for (int i = 0; i < 7; i++) rdchk(8'h23 + 8'(i), rstVal[i]);
    // Every legal routing code on both DAC fields; the reserved code is never
    // written, so each field only runs through unrouted, mixer and direct
    for (int c = 0; c < 3; c++) begin
      d = {c[1:0], c[0], ~c[0], 2'(2 - c), c[1], ~c[1]};
      wr(8'h23, d);
      rdchk(8'h23, d);
      chk({ldm, ldh, rdm, rdh, a1l, a2l, a2r, dif},
          {c == 1, c == 2, c == 1, c == 0, d[5], d[4], d[1], d[0]});
    end
    // Writes with clkEn low are not taken
    @(posedge clk) clkEn <= 1'b0;
    wr(8'h23, 8'h55);
    @(posedge clk) clkEn <= 1'b1;
    rdchk(8'h23, d);
    // Volume registers, route bit alternating
    for (int k = 0; k < 4; k++) begin
      wr(8'h24 + 8'(k), {k[0], 7'(8'h15 + k)});
      rdchk(8'h24 + 8'(k), {k[0], 7'(8'h15 + k)});
    end
    chk({lvh, lhv}, 8'h15);
    chk({rvh, rhv}, 8'h96);
    chk({lvs, lsv}, 8'h17);
    chk({rvs, rsv}, 8'h98);
    repeat (SETTLE + 6) @(posedge clk);
    // Top gain code with weak drive: flag drops, then returns
    wr(8'h28, 8'h4c);
    rdchk(8'h28, 8'h4c);
    repeat (SETTLE + 6) @(posedge clk);
    rdchk(8'h28, 8'h4d);
    chk({lhg, lum, lpz, 2'b00}, 8'h98);
    // Same gain, other bits changed: flag must stay set
    wr(8'h29, 8'h04);
    rdchk(8'h29, 8'h05);
    chk({rhg, rum, rpz, 2'b00}, 8'h08);
    // Unmapped places read as zero and keep nothing
    wr(8'h2a, 8'hff);
    rdchk(8'h2a, 8'h00);
    rdchk(8'h22, 8'h00);
    complete_run();
  end
endmodule
bind orgr_output_routing_gain_regs orgr_regs_sva u_sva (
  .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .leftDacToMixer(leftDacToMixer), .leftDacToHeadphone(leftDacToHeadphone),
  .rightDacToMixer(rightDacToMixer), .rightDacToHeadphone(rightDacToHeadphone),
  .analogInputOneToLeftMixer(analogInputOneToLeftMixer),
  .analogInputTwoToLeftMixer(analogInputTwoToLeftMixer),
  .analogInputTwoToRightMixer(analogInputTwoToRightMixer),
  .leftToRightHeadphoneDiff(leftToRightHeadphoneDiff),
  .leftVolToHeadphone(leftVolToHeadphone), .leftHeadphoneVol(leftHeadphoneVol),
  .rightVolToSpeaker(rightVolToSpeaker), .rightSpeakerVol(rightSpeakerVol),
  .leftHeadphoneGain(leftHeadphoneGain), .leftHeadphoneUnmute(leftHeadphoneUnmute),
  .leftHeadphonePdHiZ(leftHeadphonePdHiZ));
